// file: hw/acs_pkg.sv
package acs_pkg;
  // register map
  localparam logic [7:0]  ECCR_OFFSET      = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
  localparam logic [31:0] ECCR_RESET       = 32'h0000_0000;
  localparam logic [31:0] ECCR_WRITE_MASK  = 32'h0001_FE80;
  // field positions (bit 0 = least significant)
  localparam int          DIV_LSB          = 9;
  localparam int          DIV_WIDTH        = 8;
  localparam int          SRC_SEL_BIT      = 7;
  localparam int          MODE_LSB         = 0;
  localparam int          BYPASS_BIT       = 2;
  localparam int          CAPTURED_BIT     = 3;
  // source select encodings
  localparam logic        SRC_SYSTEM       = 1'b0;
  localparam logic        SRC_CRYSTAL      = 1'b1;
  // clocking modes
  typedef enum logic [1:0]
  {
    ACS_MODE_DEFAULT  = 2'h0,
    ACS_MODE_EXT_REF  = 2'h1,
    ACS_MODE_EXT_XTAL = 2'h3,
    ACS_MODE_BYPASS   = 2'h2
  } acs_mode_t;
endpackage

// file: hw/acs_clock_ctrl.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
// Summary of operation
// - the select pin and two pll pins pick one of three pll modes or a bypass mode.
// - the mode is caught from the pins when reset releases and then stays fixed.
// - the aux divider field is eight bits, its top two bits at big-endian bits 15 and 16.
// - a source select bit at big-endian bit 24 feeds the aux divider.
// - source select one picks the crystal input, zero picks the system clock.
// - after reset the aux generator runs from the system clock.
module acs_clock_ctrl #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  reset_config_select_n,
  input  wire logic [1:0]            pll_config_pins,
  input  wire logic                  crystal_input_pin,
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [31:0]           reg_rdata,
  output logic      [1:0]            pll_mode,
  output logic                       clock_bypass,
  output logic                       mode_captured,
  output logic                       aux_clock_output
);

  // pin synchronisers: three stages, a change counts once stages two and three agree
  logic [2:0] pin_sync1_reg;
  logic [2:0] pin_sync2_reg;
  logic [2:0] pin_sync3_reg;
  logic [2:0] pin_level_reg;
  logic [2:0] pin_level_next;
  logic       xtal_sync1_reg;
  logic       xtal_sync2_reg;
  logic       xtal_sync3_reg;
  logic       xtal_level_reg;
  logic       xtal_level_next;

  logic [31:0]               eccr_reg;
  logic [31:0]               eccr_next;
  acs_pkg::acs_mode_t        mode_reg;
  acs_pkg::acs_mode_t        mode_next;
  logic                      captured_reg;
  logic                      bypass_reg;
  logic [31:0]               rdata_reg;
  logic [31:0]               rdata_next;
  logic [acs_pkg::DIV_WIDTH-1:0] div_count_reg;
  logic [acs_pkg::DIV_WIDTH-1:0] div_count_next;
  logic                      aux_out_reg;
  logic                      aux_out_next;
  logic                      src_seen_reg;

  // decode of the pin combination into a clocking mode
  function automatic acs_pkg::acs_mode_t acs_decode_mode(input logic [2:0] pins);
    acs_pkg::acs_mode_t m;
    if (pins[2])
      m = acs_pkg::ACS_MODE_DEFAULT;
    else if (pins[1] && pins[0])
      m = acs_pkg::ACS_MODE_EXT_REF;
    else if (pins[1])
      m = acs_pkg::ACS_MODE_EXT_XTAL;
    else
      m = acs_pkg::ACS_MODE_BYPASS;
    return m;
  endfunction

  wire logic       pins_agree   = (pin_sync2_reg == pin_sync3_reg);
  wire logic       xtal_agree   = (xtal_sync2_reg == xtal_sync3_reg);
  wire logic       xtal_rise    = xtal_agree && xtal_sync3_reg && !xtal_level_reg;
  wire logic       capture_now  = !captured_reg;
  wire acs_pkg::acs_mode_t pin_mode = acs_decode_mode(pin_level_reg);

  wire logic       sel_eccr     = (reg_addr == ADDR_WIDTH'(acs_pkg::ECCR_OFFSET));
  wire logic       sel_status   = (reg_addr == ADDR_WIDTH'(acs_pkg::STATUS_OFFSET));
  wire logic       eccr_wr      = reg_write && sel_eccr;
  wire logic       src_sel      = eccr_reg[acs_pkg::SRC_SEL_BIT];
  wire logic [acs_pkg::DIV_WIDTH-1:0] div_value =
    eccr_reg[acs_pkg::DIV_LSB +: acs_pkg::DIV_WIDTH];
  // crystal edges or every system clock drive the divider
  wire logic       src_tick     = (src_sel == acs_pkg::SRC_CRYSTAL) ? xtal_rise : 1'b1;
  wire logic       src_changed  = (src_sel != src_seen_reg);
  wire logic       div_done     = (div_count_reg >= div_value);

  wire logic [31:0] status_word =
    {28'h000_0000, captured_reg, bypass_reg, 2'(mode_reg)};

  assign pin_level_next  = pins_agree ? pin_sync3_reg : pin_level_reg;
  assign xtal_level_next = xtal_agree ? xtal_sync3_reg : xtal_level_reg;
  assign mode_next       = capture_now ? pin_mode : mode_reg;
  assign eccr_next       = eccr_wr
                           ? ((eccr_reg & ~acs_pkg::ECCR_WRITE_MASK)
                              | (reg_wdata & acs_pkg::ECCR_WRITE_MASK))
                           : eccr_reg;
  assign rdata_next      = !reg_read   ? 32'h0000_0000 :
                           sel_eccr    ? eccr_reg :
                           sel_status  ? status_word :
                                         32'h0000_0000;
  // half period is div_value + 1 source ticks
  assign div_count_next  = src_changed ? '0 :
                           !src_tick   ? div_count_reg :
                           div_done    ? '0 :
                                         div_count_reg + 1'b1;
  assign aux_out_next    = src_changed ? 1'b0 :
                           (src_tick && div_done) ? !aux_out_reg : aux_out_reg;

  always_ff @(posedge clock)
  begin
    pin_sync1_reg  <= {reset_config_select_n, pll_config_pins};
    pin_sync2_reg  <= pin_sync1_reg;
    pin_sync3_reg  <= pin_sync2_reg;
    xtal_sync1_reg <= crystal_input_pin;
    xtal_sync2_reg <= xtal_sync1_reg;
    xtal_sync3_reg <= xtal_sync2_reg;
    // pin level keeps following the pins through reset so release sees the strap
    pin_level_reg  <= pin_level_next;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      xtal_level_reg <= 1'b0;
      mode_reg       <= acs_pkg::ACS_MODE_DEFAULT;
      captured_reg   <= 1'b0;
      bypass_reg     <= 1'b0;
    end
    else
    begin
      xtal_level_reg <= xtal_level_next;
      mode_reg       <= mode_next;
      captured_reg   <= 1'b1;
      bypass_reg     <= (mode_next == acs_pkg::ACS_MODE_BYPASS);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      eccr_reg      <= acs_pkg::ECCR_RESET;
      rdata_reg     <= 32'h0000_0000;
      div_count_reg <= '0;
      aux_out_reg   <= 1'b0;
      src_seen_reg  <= acs_pkg::SRC_SYSTEM;
    end
    else
    begin
      eccr_reg      <= eccr_next;
      rdata_reg     <= rdata_next;
      div_count_reg <= div_count_next;
      aux_out_reg   <= aux_out_next;
      src_seen_reg  <= src_sel;
    end
  end

  assign reg_rdata        = rdata_reg;
  assign pll_mode         = 2'(mode_reg);
  assign clock_bypass     = bypass_reg;
  assign mode_captured    = captured_reg;
  assign aux_clock_output = aux_out_reg;

endmodule

// file: verification/acs_monitor.sv
`timescale 1ns/1ns
module acs_monitor #(parameter int ADDR_WIDTH = 8) (
  input logic clock, sys_rst, reset_config_select_n, crystal_input_pin,
  input logic reg_write, reg_read, clock_bypass, mode_captured, aux_clock_output,
  input logic [1:0] pll_config_pins, pll_mode,
  input logic [ADDR_WIDTH-1:0] reg_addr,
  input logic [31:0] reg_wdata, reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  bypass_flag_a: assert property (mode_captured |-> clock_bypass == (pll_mode == 2'h2))
    else $error("bypass flag");
  mode_hold_a: assert property (mode_captured && $past(mode_captured) |-> $stable(pll_mode))
    else $error("mode moved");
  mode_catch_a: assert property ($fell(sys_rst) |=> mode_captured) else $error("late");
  aux_start_a: assert property ($fell(sys_rst) |-> !aux_clock_output) else $error("aux");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 0) else $error("data");
  ctrl_mask_a: assert property ($past(reg_read) && $past(reg_addr) == 0
    |-> (reg_rdata & ~acs_pkg::ECCR_WRITE_MASK) == 0) else $error("mask");
  aux_rate_a: assert property ($fell(sys_rst) ##1 !reg_write [*4] |=> $changed(aux_clock_output))
    else $error("aux rate");
endmodule
bind acs_clock_ctrl acs_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon_u (.*);

// file: verification/acs_strap_model.sv
`timescale 1ns/1ns
module acs_strap_model (input wire logic clock, sys_rst, input wire logic [2:0] strap,
  output logic reset_config_select_n, crystal_input_pin, output logic [1:0] pll_config_pins);
  initial crystal_input_pin = 1'b0;
  always #160 crystal_input_pin = ~crystal_input_pin;
  // strap held through reset, then final levels clear of all-low
  always @(posedge clock)
    {reset_config_select_n, pll_config_pins} <= sys_rst ? strap : 3'h7;
endmodule

// file: verification/acs_clock_ctrl_tb.sv
`timescale 1ns/1ns
module acs_clock_ctrl_tb;
  logic clock = 0, sys_rst = 1, reg_write = 0, reg_read = 0, clock_bypass, mode_captured;
  logic reset_config_select_n, crystal_input_pin, aux_clock_output;
  logic [1:0] pll_config_pins, pll_mode;
  logic [2:0] strap = 3'h4;
  logic [6:0] tab [4] = '{7'h48, 7'h39, 7'h2B, 7'h1E};
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, lfsr = 32'hA66C78FB, d, reg_rdata;
  int failures = 0, checks = 0, t;
  always #20 clock = ~clock;
  acs_strap_model bd_u (.*);
  acs_clock_ctrl dut_u (.*);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h0);
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    failures += seen !== exp;
    if (seen !== exp) $display("[FAIL] %0t got %h want %h", $time, seen, exp);
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    {reg_write, reg_read} <= {wr, !wr};
    @(posedge clock);
    {reg_write, reg_read} <= 2'h0;
    @(negedge clock);
    if (!wr) check(reg_rdata, v);
    @(posedge clock);
  endtask
  task final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #1000000 failures++;
    final_report;
  end
  initial
  begin
    foreach (tab[i])
    begin
      strap <= tab[i][6:4];
      sys_rst <= 1;
      repeat (20) @(posedge clock);
      sys_rst <= 0;
      repeat (3) @(posedge clock);
      bus(0, 8'h04, tab[i][3:0]);
      bus(0, 8'h00, 32'h0);
    end
    bus(1, 8'h08, 32'hFFFFFFFF);
    bus(0, 8'h08, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      lfsr = nxt(lfsr);
      d = i == 0 ? 32'h0001FE00 : i > 5 ? lfsr & 32'hFFFE0FFF | 32'h80 : lfsr & 32'hFFFFFF7F;
      bus(1, 8'h00, d);
      bus(0, 8'h00, d & acs_pkg::ECCR_WRITE_MASK);
      // first edge after a write may come from a partial count, skip it
      @(aux_clock_output);
      @(aux_clock_output);
      t = $stime;
      @(aux_clock_output);
      check(($stime - t) / 40, (d[16:9] + 1) * (d[7] ? 8 : 1));
    end
    final_report;
  end
endmodule
